/* verilog/tcc_pkg.sv */
// Constants for the timer counter core: register indices, fields, resets.
// Assumes a word-addressed Avalon-MM slave, one register per word index.
package tcc_pkg;
  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int          NUM_CH      = 4;
  localparam int          IDX_W       = 6;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CNT_ONE     = 16'h0001;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  localparam logic [5:0]  DIV64_LAST  = 6'h3F;
  localparam logic [5:0]  DIV64_ONE   = 6'h01;
  localparam logic [7:0]  PRE_ONE     = 8'h01;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_MODE     = 6'h00;
  localparam logic [5:0] IDX_FORCE    = 6'h01;
  localparam logic [5:0] IDX_CNT_HI   = 6'h04;
  localparam logic [5:0] IDX_CNT_LO   = 6'h05;
  localparam logic [5:0] IDX_SYSCTL1  = 6'h06;
  localparam logic [5:0] IDX_TOV      = 6'h07;
  localparam logic [5:0] IDX_ACTION   = 6'h09;
  localparam logic [5:0] IDX_SYSCTL2  = 6'h0D;
  localparam logic [5:0] IDX_CHFLAG   = 6'h0E;
  localparam logic [5:0] IDX_OVFLAG   = 6'h0F;
  localparam logic [5:0] IDX_CMP_BASE = 6'h10;
  localparam logic [5:0] IDX_CMP_LAST = 6'h17;
  localparam logic [5:0] IDX_PRESC    = 6'h2E;
  localparam logic [5:0] IDX_CNT_WORD = 6'h30;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SC1_EN   = 7;
  localparam int SC1_SWAI = 6;
  localparam int SC1_SFRZ = 5;
  localparam int SC1_FFCA = 4;
  localparam int SC1_PRECISION_PRESCALE_SELECT = 3;
  localparam int OVF_TOF  = 7;
  localparam int PR_HI    = 2;

  // ************************************************************
  // Output actions on a compare event
  // ************************************************************
  typedef enum logic [1:0] {
    TCC_ACT_NONE = 2'h0,
    TCC_ACT_TGL  = 2'h1,
    TCC_ACT_LOW  = 2'h2,
    TCC_ACT_HIGH = 2'h3
  } tcc_act_t;
endpackage : tcc_pkg

/* verilog/tcc_prescaler.sv */
// Prescaler for the timer counter core: counter tick and divide-by-64 pulse.
// Assumes run and selections come from registers on the same clock.
module tcc_prescaler (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       run,
  input  wire logic       precise,
  input  wire logic [2:0] legacySel,
  input  wire logic [7:0] preciseDiv,
  // Pulses
  output logic            tick,
  output logic            div64
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] pre;
    logic       tick;
    logic [5:0] d64;
    logic       div64;
  } tcc_pre_t;

  tcc_pre_t   s_q;
  tcc_pre_t   s_d;
  logic [7:0] limit;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d   = s_q;
    limit = precise ? preciseDiv
                    : 8'((tcc_pkg::PRE_ONE << legacySel) - tcc_pkg::PRE_ONE);
    s_d.tick  = 1'b0;
    s_d.div64 = 1'b0;
    if (run) begin
      // Never reset by a counter write, so the first period may vary
      if (s_q.pre >= limit) begin
        s_d.pre  = tcc_pkg::BYTE_ZERO;
        s_d.tick = 1'b1;
      end else begin
        s_d.pre = s_q.pre + tcc_pkg::PRE_ONE;
      end
      s_d.d64   = s_q.d64 + tcc_pkg::DIV64_ONE;
      s_d.div64 = (s_q.d64 == tcc_pkg::DIV64_LAST);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick  = s_q.tick;
  assign div64 = s_q.div64;
endmodule : tcc_prescaler

/* verilog/tcc_core.sv */
// Timer counter core: 16-bit counter, four capture/compare channels.
// Assumes an Avalon-MM master on mclk and pins from outside the domain.
// What this block does
// - Writing a force bit performs that channel's compare action at once.
// - A forced compare action never sets the channel flag.
// - Forced action beats a simultaneous real match; flag stays clear.
// - The force register always reads as zero.
// - Bits of missing channels ignore writes and read zero.
// - Counter is 16 bits and counts up on each prescaled tick.
// - Software reads or writes the counter as one word at once.
// - Counter writes only take effect in special mode.
// - Prescaler is not restarted by a counter write.
// - Enable bit clear stops the prescaler and counter; forced actions and captures still work.
// - No divide-by-64 pulse while the timer is inactive.
// - Stop-in-wait halts timer and divide-by-64 during wait.
// - Stop-in-freeze halts only the counter during freeze.
// - Fast clear: capture read or compare write clears channel flag.
// - Fast clear: any counter access clears the overflow flag.
// - Precision bit picks eight-bit prescaler instead of legacy field.
// - Precision select bit accepts only its first write after reset.
// - Toggle-on-overflow flips a compare output on counter wrap.
// - Toggle-on-overflow beats a simultaneous forced action.
// - Channel mode bit: 0 input capture, 1 output compare.
// - Action bits: none, toggle, drive low, drive high.
module tcc_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // System modes
  input  wire logic        waitMode,
  input  wire logic        freezeMode,
  input  wire logic        specialMode,
  // Channel pins
  input  wire logic [3:0]  chanIn,
  output logic      [3:0]  chanOut,
  output logic      [3:0]  chanOe,
  // Pulse accumulator clock
  output logic             div64Tick
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic        waitReq;
    logic [31:0] rdata;
    logic [15:0] cnt;
    logic [3:0]  channel_mode_bit;
    logic [7:0]  action;
    logic        en;
    logic        swai;
    logic        sfrz;
    logic        ffca;
    logic        precision_prescale_select;
    logic        prntLocked;
    logic [2:0]  pr;
    logic [7:0]  ptps;
    logic [3:0]  overflow_toggle_bit;
    logic [3:0]  cflag;
    logic        counter_overflow_flag;
    logic [63:0] cmp;
    logic [3:0]  forceS;
    logic [3:0]  pinOut;
    logic [3:0]  pinOe;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  stable;
  } tcc_state_t;

  tcc_state_t  s_q;
  tcc_state_t  s_d;
  logic        preTick;
  logic        paRun;
  logic        cntRun;
  logic        cntTick;
  logic        ovf;
  logic        wrEn;
  logic        rdAcc;
  logic        cntAccess;
  logic [15:0] cntNext;
  logic [7:0]  rdByte;
  logic [7:0]  wd;
  logic [5:0]  cmpOff;
  logic [3:0]  rise;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic applyAct(input logic cur, input logic [1:0] a);
    case (tcc_pkg::tcc_act_t'(a))
      tcc_pkg::TCC_ACT_TGL:  applyAct = ~cur;
      tcc_pkg::TCC_ACT_LOW:  applyAct = 1'b0;
      tcc_pkg::TCC_ACT_HIGH: applyAct = 1'b1;
      default:               applyAct = cur;
    endcase
  endfunction : applyAct

  function automatic logic isCmp(input logic [5:0] idx);
    isCmp = (idx >= tcc_pkg::IDX_CMP_BASE) && (idx <= tcc_pkg::IDX_CMP_LAST);
  endfunction : isCmp

  // ************************************************************
  // Prescaler
  // ************************************************************
  tcc_prescaler tcc_prescaler_i (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .run        (paRun),
    .precise    (s_q.precision_prescale_select),
    .legacySel  (s_q.pr),
    .preciseDiv (s_q.ptps),
    .tick       (preTick),
    .div64      (div64Tick)
  );

  // Freeze stops the counter only; wait stops the prescaler too
  assign paRun   = s_q.en && !(waitMode && s_q.swai);
  assign cntRun  = paRun && !(freezeMode && s_q.sfrz);
  assign cntTick = preTick && cntRun;
  assign cntNext = s_q.cnt + tcc_pkg::CNT_ONE;
  assign ovf     = cntTick && (s_q.cnt == tcc_pkg::CNT_MAX);

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Requests are taken on the edge where waitrequest is low
  assign wrEn   = avs_write && !s_q.waitReq && avs_byteenable[0];
  assign rdAcc  = avs_read && !s_q.waitReq;
  assign wd     = avs_writedata[7:0];
  assign cmpOff = avs_address - tcc_pkg::IDX_CMP_BASE;
  assign cntAccess = (rdAcc || wrEn) &&
                     (avs_address == tcc_pkg::IDX_CNT_HI ||
                      avs_address == tcc_pkg::IDX_CNT_LO ||
                      avs_address == tcc_pkg::IDX_CNT_WORD);

  always_comb begin
    rdByte = tcc_pkg::BYTE_ZERO;
    case (avs_address)
      tcc_pkg::IDX_MODE:    rdByte = {4'h0, s_q.channel_mode_bit};
      tcc_pkg::IDX_FORCE:   rdByte = tcc_pkg::BYTE_ZERO;
      tcc_pkg::IDX_CNT_HI:  rdByte = s_q.cnt[15:8];
      tcc_pkg::IDX_CNT_LO:  rdByte = s_q.cnt[7:0];
      tcc_pkg::IDX_SYSCTL1: rdByte = {s_q.en, s_q.swai, s_q.sfrz, s_q.ffca,
                                      s_q.precision_prescale_select, 3'h0};
      tcc_pkg::IDX_TOV:     rdByte = {4'h0, s_q.overflow_toggle_bit};
      tcc_pkg::IDX_ACTION:  rdByte = s_q.action;
      tcc_pkg::IDX_SYSCTL2: rdByte = {5'h00, s_q.pr};
      tcc_pkg::IDX_CHFLAG:  rdByte = {4'h0, s_q.cflag};
      tcc_pkg::IDX_OVFLAG:  rdByte = {s_q.counter_overflow_flag, 7'h00};
      tcc_pkg::IDX_PRESC:   rdByte = s_q.ptps;
      default: begin
        if (isCmp(avs_address)) begin
          rdByte = cmpOff[0] ? s_q.cmp[16*cmpOff[2:1] +: 8]
                             : s_q.cmp[16*cmpOff[2:1] + 8 +: 8];
        end
      end
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    // One wait cycle, then the answer edge
    s_d.waitReq = !(s_q.waitReq && (avs_read || avs_write));
    if (avs_read && s_q.waitReq) begin
      s_d.rdata = (avs_address == tcc_pkg::IDX_CNT_WORD)
                ? {16'h0000, s_q.cnt} : {24'h000000, rdByte};
    end

    // Pin synchroniser; a change counts once stages two and three agree
    s_d.sync1  = chanIn;
    s_d.sync2  = s_q.sync1;
    s_d.sync3  = s_q.sync2;
    s_d.stable = (s_q.sync2 & s_q.sync3) |
                 (s_q.stable & (s_q.sync2 ^ s_q.sync3));
    rise = s_d.stable & ~s_q.stable;

    // Counter
    if (cntTick) begin
      s_d.cnt = cntNext;
    end
    if (wrEn && specialMode) begin
      if (avs_address == tcc_pkg::IDX_CNT_HI) begin
        s_d.cnt[15:8] = wd;
      end
      if (avs_address == tcc_pkg::IDX_CNT_LO) begin
        s_d.cnt[7:0] = wd;
      end
      if (avs_address == tcc_pkg::IDX_CNT_WORD && avs_byteenable[1]) begin
        s_d.cnt = avs_writedata[15:0];
      end
    end

    // Overflow flag; hardware set wins over any clear
    s_d.counter_overflow_flag = ovf || (s_q.counter_overflow_flag &&
              !(wrEn && avs_address == tcc_pkg::IDX_OVFLAG &&
                wd[tcc_pkg::OVF_TOF]) &&
              !(s_q.ffca && cntAccess));

    // Control registers
    s_d.forceS = '0;
    if (wrEn) begin
      case (avs_address)
        tcc_pkg::IDX_MODE:    s_d.channel_mode_bit    = wd[3:0];
        tcc_pkg::IDX_FORCE:   s_d.forceS = wd[3:0];
        tcc_pkg::IDX_TOV:     s_d.overflow_toggle_bit    = wd[3:0];
        tcc_pkg::IDX_ACTION:  s_d.action = wd;
        tcc_pkg::IDX_SYSCTL2: s_d.pr     = wd[tcc_pkg::PR_HI:0];
        tcc_pkg::IDX_PRESC:   s_d.ptps   = wd;
        tcc_pkg::IDX_SYSCTL1: begin
          s_d.en   = wd[tcc_pkg::SC1_EN];
          s_d.swai = wd[tcc_pkg::SC1_SWAI];
          s_d.sfrz = wd[tcc_pkg::SC1_SFRZ];
          s_d.ffca = wd[tcc_pkg::SC1_FFCA];
          if (!s_q.prntLocked) begin
            s_d.precision_prescale_select       = wd[tcc_pkg::SC1_PRECISION_PRESCALE_SELECT];
            s_d.prntLocked = 1'b1;
          end
        end
        default: begin
          if (isCmp(avs_address)) begin
            if (cmpOff[0]) begin
              s_d.cmp[16*cmpOff[2:1] +: 8] = wd;
            end else begin
              s_d.cmp[16*cmpOff[2:1] + 8 +: 8] = wd;
            end
          end
        end
      endcase
    end

    // Channels
    for (int i = 0; i < tcc_pkg::NUM_CH; i++) begin
      logic       oc;
      logic       match;
      logic       forced;
      logic       setF;
      logic       clrF;
      logic [1:0] act;
      oc     = s_q.channel_mode_bit[i];
      act    = s_q.action[2*i +: 2];
      match  = oc && cntTick && (cntNext == s_q.cmp[16*i +: 16]);
      forced = oc && s_q.forceS[i];
      s_d.pinOe[i] = oc && (act != 2'h0);
      if (oc && ovf && s_q.overflow_toggle_bit[i]) begin
        s_d.pinOut[i] = ~s_q.pinOut[i];
      end else if (forced) begin
        s_d.pinOut[i] = applyAct(s_q.pinOut[i], act);
      end else if (match) begin
        s_d.pinOut[i] = applyAct(s_q.pinOut[i], act);
      end
      if (!oc && rise[i]) begin
        s_d.cmp[16*i +: 16] = s_q.cnt;
      end
      setF = (match && !forced) || (!oc && rise[i]);
      clrF = (wrEn && avs_address == tcc_pkg::IDX_CHFLAG && wd[i]) ||
             (s_q.ffca && isCmp(avs_address) && cmpOff[2:1] == 2'(i) &&
              ((rdAcc && !oc) || (wrEn && oc)));
      s_d.cflag[i] = setF || (s_q.cflag[i] && !clrF);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.waitReq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign chanOut         = s_q.pinOut;
  assign chanOe          = s_q.pinOe;

  // ************************************************************
  // Checks
  // ************************************************************
  force_read_zero_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (avs_read && s_q.waitReq && avs_address == tcc_pkg::IDX_FORCE)
    |=> (avs_readdata == tcc_pkg::WORD_ZERO))
    else $error("force register read nonzero");

  forced_no_flag_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.forceS[0] && s_q.channel_mode_bit[0] && !s_q.cflag[0]) |=> !s_q.cflag[0])
    else $error("forced compare set a flag");

  wait_answer_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

  counter_hold_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!s_q.en && !specialMode) |=> $stable(s_q.cnt))
    else $error("counter moved while disabled");

  normal_write_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (wrEn && !specialMode && !cntTick) |=> $stable(s_q.cnt))
    else $error("counter written in normal mode");

  wrap_flag_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cntTick && s_q.cnt == tcc_pkg::CNT_MAX)
    |=> (s_q.counter_overflow_flag && s_q.cnt == tcc_pkg::CNT_RST) or (specialMode && s_q.counter_overflow_flag))
    else $error("wrap did not set overflow");

  precision_prescale_select_once_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_q.prntLocked |=> ($stable(s_q.precision_prescale_select) && s_q.prntLocked))
    else $error("precision select rewritten");

  ovf_toggle_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (ovf && |(s_q.overflow_toggle_bit & s_q.channel_mode_bit))
    |=> (((chanOut ^ $past(chanOut)) & $past(s_q.overflow_toggle_bit) & $past(s_q.channel_mode_bit))
         == ($past(s_q.overflow_toggle_bit) & $past(s_q.channel_mode_bit))))
    else $error("overflow toggle missing");

  force_action_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (s_q.forceS[1] && s_q.channel_mode_bit[1] && !(ovf && s_q.overflow_toggle_bit[1]) &&
     s_q.action[3:2] == tcc_pkg::TCC_ACT_LOW) |=> !chanOut[1])
    else $error("forced drive low missing");

  wait_div64_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (waitMode && s_q.swai) |=> !div64Tick)
    else $error("divide-by-64 during wait stop");

  div64_idle_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!s_q.en)[*2] |-> !div64Tick)
    else $error("divide-by-64 while inactive");
endmodule : tcc_core

/* sim/tcc_core_tb.sv */
// Self-checking bench for the timer counter core.
// Assumes tcc_pkg and tcc_core are compiled first; one 100 MHz clock.
module tcc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        mclk;
  logic        sys_rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        waitMode;
  logic        freezeMode;
  logic        specialMode;
  logic [3:0]  chanIn;
  logic [3:0]  chanOut;
  logic [3:0]  chanOe;
  logic        div64Tick;
  int          numErrors;
  int          nChecks;

  tcc_core tcc_core_i (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .waitMode(waitMode), .freezeMode(freezeMode),
    .specialMode(specialMode), .chanIn(chanIn), .chanOut(chanOut),
    .chanOe(chanOe), .div64Tick(div64Tick)
  );

  always #5 mclk = ~mclk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 20) begin
      chk(32'h0000_0001, 32'h0000_0000, "bus timeout");
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  // Counts divide-by-64 pulses over n cycles
  task automatic cnt(input int n, output logic [31:0] k);
    k = 32'h0000_0000;
    repeat (n) begin
      @(posedge mclk);
      if (div64Tick === 1'b1) begin
        k++;
      end
    end
  endtask : cnt

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] q;
    logic [5:0]  idx [6];
    idx = '{tcc_pkg::IDX_FORCE, tcc_pkg::IDX_TOV, tcc_pkg::IDX_SYSCTL1,
            tcc_pkg::IDX_CNT_WORD, tcc_pkg::IDX_MODE, tcc_pkg::IDX_ACTION};
    foreach (idx[i]) begin
      rd(idx[i], q);
      chk(q, 32'h0000_0000, "reset value");
    end
    chk({28'h0, chanOut}, 32'h0000_0000, "reset out");
    chk({28'h0, chanOe}, 32'h0000_0000, "reset oe");
    // Unmapped index must swallow the write
    wr(6'h3F, 32'h0000_00A5);
    rd(6'h3F, q);
    chk(q, 32'h0000_0000, "unmapped");
    $display("done reset");
  endtask : t_reset

  task automatic t_force();
    logic [31:0] q;
    wr(tcc_pkg::IDX_MODE, 32'h0000_00FF);
    rd(tcc_pkg::IDX_MODE, q);
    chk(q, 32'h0000_000F, "mode bits");
    // ch0 high, ch1 low, ch2 toggle, ch3 none
    wr(tcc_pkg::IDX_ACTION, 32'h0000_001B);
    wr(tcc_pkg::IDX_FORCE, 32'h0000_00F0);
    repeat (3) @(posedge mclk);
    chk({28'h0, chanOut}, 32'h0000_0000, "absent force");
    wr(tcc_pkg::IDX_FORCE, 32'h0000_000F);
    repeat (3) @(posedge mclk);
    chk({28'h0, chanOut}, 32'h0000_0005, "forced out");
    chk({28'h0, chanOe}, 32'h0000_0007, "forced oe");
    rd(tcc_pkg::IDX_CHFLAG, q);
    chk(q, 32'h0000_0000, "no flag");
    rd(tcc_pkg::IDX_FORCE, q);
    chk(q, 32'h0000_0000, "force reads 0");
    wr(tcc_pkg::IDX_FORCE, 32'h0000_0004);
    repeat (3) @(posedge mclk);
    chk({28'h0, chanOut}, 32'h0000_0001, "toggle back");
    $display("done force");
  endtask : t_force

  task automatic t_count();
    logic [31:0] q;
    logic [31:0] q1;
    // First control write locks the legacy prescaler
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0010);
    wr(tcc_pkg::IDX_CNT_WORD, 32'h0000_FFF0);
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk(q, 32'h0000_0000, "normal write");
    specialMode <= 1'b1;
    wr(tcc_pkg::IDX_CNT_WORD, 32'h0000_FFF0);
    specialMode <= 1'b0;
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk(q, 32'h0000_FFF0, "special write");
    wr(tcc_pkg::IDX_CMP_BASE, 32'h0000_0000);
    wr(tcc_pkg::IDX_CMP_BASE + 6'h01, 32'h0000_0000);
    wr(tcc_pkg::IDX_TOV, 32'h0000_00F8);
    rd(tcc_pkg::IDX_TOV, q);
    chk(q, 32'h0000_0008, "tov bits");
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0090);
    rd(tcc_pkg::IDX_CNT_WORD, q1);
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk({31'h0, q[15:0] > q1[15:0]}, 32'h0000_0001, "counts up");
    repeat (40) @(posedge mclk);
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0010);
    rd(tcc_pkg::IDX_OVFLAG, q);
    chk(q, 32'h0000_0080, "overflow");
    rd(tcc_pkg::IDX_CHFLAG, q);
    chk({31'h0, q[0]}, 32'h0000_0001, "match flag");
    chk({31'h0, chanOut[3]}, 32'h0000_0001, "tov toggle");
    rd(tcc_pkg::IDX_CNT_LO, q);
    rd(tcc_pkg::IDX_OVFLAG, q);
    chk(q, 32'h0000_0000, "fast ovf clear");
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk({24'h0, q[15:8]}, 32'h0000_0000, "wrapped");
    wr(tcc_pkg::IDX_CMP_BASE + 6'h01, 32'h0000_0000);
    rd(tcc_pkg::IDX_CHFLAG, q);
    chk({31'h0, q[0]}, 32'h0000_0000, "fast ch clear");
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0018);
    rd(tcc_pkg::IDX_SYSCTL1, q);
    chk(q, 32'h0000_0010, "select locked");
    $display("done count");
  endtask : t_count

  task automatic t_div64();
    logic [31:0] k;
    logic [31:0] q;
    logic [31:0] q1;
    cnt(256, k);
    chk(k, 32'h0000_0000, "off no div64");
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0080);
    cnt(256, k);
    chk(k, 32'h0000_0004, "div64 rate");
    waitMode <= 1'b1;
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_00C0);
    rd(tcc_pkg::IDX_CNT_WORD, q1);
    cnt(256, k);
    chk(k, 32'h0000_0000, "wait div64");
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk(q, q1, "wait count");
    waitMode   <= 1'b0;
    freezeMode <= 1'b1;
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_00A0);
    rd(tcc_pkg::IDX_CNT_WORD, q1);
    cnt(256, k);
    chk(k, 32'h0000_0004, "freeze div64");
    rd(tcc_pkg::IDX_CNT_WORD, q);
    chk(q, q1, "freeze count");
    freezeMode <= 1'b0;
    $display("done div64");
  endtask : t_div64

  task automatic t_prec();
    logic [31:0] q;
    logic [31:0] q1;
    // Second reset mid-run frees the precision select again
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    chk({28'h0, chanOut}, 32'h0000_0000, "reset out again");
    // Low byte lane off, so the write must be dropped
    avs_byteenable <= 4'hE;
    wr(tcc_pkg::IDX_TOV, 32'h0000_000F);
    avs_byteenable <= 4'hF;
    rd(tcc_pkg::IDX_TOV, q);
    chk(q, 32'h0000_0000, "reset tov again");
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0008);
    wr(tcc_pkg::IDX_PRESC, 32'h0000_0003);
    wr(tcc_pkg::IDX_SYSCTL1, 32'h0000_0080);
    rd(tcc_pkg::IDX_SYSCTL1, q);
    chk(q, 32'h0000_0088, "select kept");
    // Captures 43 edges apart; divide by four gives 10 or 11 steps
    rd(tcc_pkg::IDX_CNT_WORD, q1);
    repeat (40) @(posedge mclk);
    rd(tcc_pkg::IDX_CNT_WORD, q);
    q = q - q1;
    chk({31'h0, q == 32'h0000_000A || q == 32'h0000_000B},
        32'h0000_0001, "precision rate");
    $display("done prec");
  endtask : t_prec

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    waitMode = 1'b0;
    freezeMode = 1'b0;
    specialMode = 1'b0;
    chanIn = 4'h0;
    numErrors = 0;
    nChecks = 0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_force();
    t_count();
    t_div64();
    t_prec();
    stop_test();
  end
endmodule : tcc_core_tb
